// File: core/ass_defs.vh
// Constants for the sleep-state sequencer: timing counts and cap-control codes
`ifndef ASS_DEFS_VH
`define ASS_DEFS_VH

// Clock rate
`define ASS_CLK_MHZ          50
// Settle wait before memory supply soft-start, in microseconds
`define ASS_SETTLE_US        100
`define ASS_SETTLE_CYC       (`ASS_SETTLE_US * `ASS_CLK_MHZ)
// Width of the settle counter
`define ASS_CNT_W            13

// Soft-start cap control codes
`define ASS_CAP_W            3
`define ASS_CAP_DISCH        3'h0
`define ASS_CAP_HOLD0        3'h1
`define ASS_CAP_CHARGE       3'h2
`define ASS_CAP_HOLD12       3'h3
`define ASS_CAP_TO2V         3'h4

// Standby switch gate drive codes
`define ASS_GATE_W           2
`define ASS_GATE_HIGH        2'h0
`define ASS_GATE_WEAK        2'h1
`define ASS_GATE_STRONG      2'h2

`endif

// File: core/ass_sync.v
// Two-flop synchroniser bank for the analog comparator flags
`timescale 1ns/1ns
module ass_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         reset_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta;
  reg [W-1:0] sync;

  // First stage feeds only the second stage
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= {W{1'b0}};
      sync <= {W{1'b0}};
    end else begin
      meta <= d_i;
      sync <= meta;
    end
  end

  assign q_o = sync;
endmodule

// File: core/ass_sequencer.v
// Sleep-state sequencer for a memory-power regulator (S5, S3, S0)
`timescale 1ns/1ns
`include "ass_defs.vh"
module ass_sequencer (
  input  wire                  clk_i,
  input  wire                  reset_i,
  input  wire                  uvlo_ok_i,
  input  wire                  startup_done_i,
  input  wire                  main5_good_i,
  input  wire                  main5_above_4v5_i,
  input  wire                  cap_at_1v3_i,
  input  wire                  cap_discharged_i,
  input  wire                  standby_request_n_i,
  input  wire                  soft_off_enable_n_i,
  output reg                   memory_supply_en_o,
  output reg                   termination_en_o,
  output reg                   always_on_33_en_o,
  output reg                   standby_status_out_n_o,
  output reg                   standby_switch_gate_o,
  output reg  [`ASS_GATE_W-1:0] gate_drive_o,
  output reg                   pass_fet_en_o,
  output reg  [`ASS_CAP_W-1:0]  softstart_cap_ctl_o,
  output reg                   memory_supply_good_o,
  output wire [4:0]            state_o
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  // START keeps the power-up pattern until the startup interval is over.
  // S5 is soft-off with only the always-on LDO running. SETTLE is the step
  // from S5 to S3: the standby switch gate is already low and the cap is
  // emptied before the memory supply may ramp. S3 and S0 are the two
  // states in which the memory supply runs.
  localparam [4:0] ST_START  = 5'b00001;
  localparam [4:0] ST_S5     = 5'b00010;
  localparam [4:0] ST_SETTLE = 5'b00100;
  localparam [4:0] ST_S3     = 5'b01000;
  localparam [4:0] ST_S0     = 5'b10000;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  wire [7:0] raw = {soft_off_enable_n_i,   // Bit 7
                    standby_request_n_i,   // Bit 6
                    cap_discharged_i,      // Bit 5
                    cap_at_1v3_i,          // Bit 4
                    main5_above_4v5_i,     // Bit 3
                    main5_good_i,          // Bit 2
                    startup_done_i,        // Bit 1
                    uvlo_ok_i};            // Bit 0
  wire [7:0] syn;

  // Comparators are asynchronous to our clock; the two-flop delay is the
  // price paid for decisions that never see a half-settled flag
  ass_sync #(.W(8)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (raw),
    .q_o     (syn)
  );

  wire uvlo_ok   = syn[0];
  wire start_ok  = syn[1];
  wire m5_good   = syn[2];
  wire m5_4v5    = syn[3];
  wire cap_1v3   = syn[4];
  wire cap_zero  = syn[5];
  wire req_n     = syn[6];
  wire soft_on   = syn[7];

  // from_s5 marks that S3 is being reached from soft-off, the only path on
  // which the standby switch gate may need its inrush-limited pull
  reg [4:0]             state;
  reg [4:0]             next_state;
  reg [`ASS_CNT_W-1:0]  settle_cnt;
  reg                   req_d;
  reg                   from_s5;
  reg                   next_from_s5;

  assign state_o = state;

  // Falling edge of the standby request, from synchronised samples only
  wire req_fall = req_d & ~req_n;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Memory rail states: the supply runs in S3 and in S0 alike
  function rails_up;
    input [4:0] st;
    begin
      rails_up = (st == ST_S3) || (st == ST_S0);
    end
  endfunction

  // Next memory supply good flag. It latches on the 1.3V crossing, and the
  // crossing only counts while main 5V is good. In S3 a later dip of main 5V
  // keeps the flag, since the cap stays parked at 1.2V (2V after S0) and cannot ramp again;
  // in S0 a dip clears it, but termination stays on while the cap reads above 1.3V.
  function good_next;
    input cur;
    input crossed;
    input main_ok;
    input keep_on_dip;
    begin
      if (keep_on_dip) begin
        good_next = cur || (main_ok && crossed);
      end else begin
        good_next = main_ok && (cur || crossed);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Every flag seen here is two flops behind its pin, and the outputs are
  // registered off next_state, so a pin change shows on the rails at the
  // third edge. Undervoltage lockout is checked last so that it overrides
  // every other transition and forces everything back to startup.
  always @* begin
    next_state   = state;
    next_from_s5 = from_s5;
    case (state)
      ST_START: begin
        // Inputs ignored until the startup interval completes
        if (start_ok) begin
          next_state = ST_S5;
        end
      end
      ST_S5: begin
        next_from_s5 = 1'b1;
        if (soft_on) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // Go on to S3 only with the cap fully empty, so the memory supply
        // soft-start never begins from a residual charge
        if (!soft_on) begin
          next_state = ST_S5;
        end else if (m5_good && settle_cnt >= `ASS_SETTLE_CYC && cap_zero) begin
          next_state = ST_S3;
        end
      end
      ST_S3: begin
        next_from_s5 = 1'b0;
        if (!soft_on) begin
          next_state = ST_S5;
        end else if (req_n && m5_good) begin
          next_state = ST_S0;
        end
      end
      ST_S0: begin
        if (!soft_on) begin
          next_state = ST_S5;
        end else if (req_fall || !req_n) begin
          next_state = ST_S3;
        end
      end
      default: begin
        next_state = ST_START;
      end
    endcase
    if (!uvlo_ok) begin
      next_state = ST_START;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Request is delayed one cycle to find its falling edge
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state      <= ST_START;
      req_d      <= 1'b0;
      from_s5    <= 1'b1;
    end else begin
      state   <= next_state;
      req_d   <= req_n;
      from_s5 <= next_from_s5;
    end
  end

  // ----------------------------------------------------------------
  // Settle counter
  // ----------------------------------------------------------------
  // Counts only while main 5V stays good, so the wait restarts on a dip.
  // It parks at the full count rather than wrapping, so a slow cap
  // discharge still finds the wait satisfied when it completes.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      settle_cnt <= {`ASS_CNT_W{1'b0}};
    end else if (state == ST_SETTLE && m5_good) begin
      if (settle_cnt < `ASS_SETTLE_CYC) begin
        settle_cnt <= settle_cnt + 1'b1;
      end
    end else begin
      settle_cnt <= {`ASS_CNT_W{1'b0}};
    end
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // All outputs registered so rail enables never glitch. They are decoded
  // from next_state, so they change on the same edge as the state register
  // and a rail never lags the state it belongs to by a cycle.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      memory_supply_en_o     <= 1'b0;
      termination_en_o       <= 1'b0;
      always_on_33_en_o      <= 1'b0;
      standby_status_out_n_o <= 1'b0;
      standby_switch_gate_o  <= 1'b1;
      gate_drive_o           <= `ASS_GATE_HIGH;
      pass_fet_en_o          <= 1'b0;
      softstart_cap_ctl_o    <= `ASS_CAP_DISCH;
      memory_supply_good_o   <= 1'b0;
    end else begin
      // Pass transistors follow the 4.5V comparator, only in S0; closing them
      // early would back-feed the dual rail from a main 5V still ramping
      pass_fet_en_o <= (next_state == ST_S0) && m5_4v5;
      // Memory supply requires main 5V good at every instant
      memory_supply_en_o <= m5_good && rails_up(next_state);
      case (next_state)
        ST_START: begin
          always_on_33_en_o      <= 1'b1;
          termination_en_o       <= 1'b0;
          standby_status_out_n_o <= 1'b0;
          standby_switch_gate_o  <= 1'b1;
          gate_drive_o           <= `ASS_GATE_HIGH;
          softstart_cap_ctl_o    <= `ASS_CAP_DISCH;
          memory_supply_good_o   <= 1'b0;
        end
        ST_S5, ST_SETTLE: begin
          always_on_33_en_o      <= 1'b1;
          termination_en_o       <= 1'b0;
          standby_status_out_n_o <= 1'b0;
          standby_switch_gate_o  <= (next_state == ST_S5); // Gate goes low once S3 is pending
          gate_drive_o           <= (next_state == ST_S5) ? `ASS_GATE_HIGH :
                                    (m5_good ? `ASS_GATE_STRONG : `ASS_GATE_WEAK);
          // Settle wait discharges, S5 clamps the cap at 0V
          softstart_cap_ctl_o    <= (next_state == ST_S5) ? `ASS_CAP_HOLD0 : `ASS_CAP_DISCH;
          memory_supply_good_o   <= 1'b0;
        end
        ST_S3: begin
          always_on_33_en_o      <= 1'b1;
          standby_status_out_n_o <= 1'b0;
          termination_en_o       <= 1'b0;
          standby_switch_gate_o  <= 1'b0;
          // Inrush-limited pull-down only matters coming up from S5
          gate_drive_o           <= (from_s5 && !m5_good) ? `ASS_GATE_WEAK : `ASS_GATE_STRONG;
          // The 2V discharge stays in force for the whole stay after S0, or
          // the good flag would pull the cap straight back to 1.2V
          if (state == ST_S0 || softstart_cap_ctl_o == `ASS_CAP_TO2V) begin
            softstart_cap_ctl_o  <= `ASS_CAP_TO2V;
          end else if (memory_supply_good_o || cap_1v3) begin
            softstart_cap_ctl_o  <= `ASS_CAP_HOLD12;
          end else begin
            softstart_cap_ctl_o  <= `ASS_CAP_CHARGE;
          end
          // Good flag latches on the 1.3V crossing and survives a main 5V dip
          memory_supply_good_o   <= good_next(memory_supply_good_o, cap_1v3, m5_good, 1'b1);
        end
        ST_S0: begin
          standby_status_out_n_o <= 1'b1;
          standby_switch_gate_o  <= 1'b1;
          gate_drive_o           <= `ASS_GATE_HIGH;
          always_on_33_en_o      <= 1'b0;
          // Termination waits for the memory supply good flag or the 1.3V cap comparator
          termination_en_o       <= memory_supply_good_o || cap_1v3;
          softstart_cap_ctl_o    <= `ASS_CAP_CHARGE;
          memory_supply_good_o   <= good_next(memory_supply_good_o, cap_1v3, m5_good, 1'b0);
        end
        default: begin
          always_on_33_en_o      <= 1'b1;
          termination_en_o       <= 1'b0;
          standby_status_out_n_o <= 1'b0;
          standby_switch_gate_o  <= 1'b1;
          gate_drive_o           <= `ASS_GATE_HIGH;
          softstart_cap_ctl_o    <= `ASS_CAP_DISCH;
          memory_supply_good_o   <= 1'b0;
        end
      endcase
    end
  end
endmodule

// File: tb/ass_cap_model.sv
// Behavioural soft-start capacitor with its threshold comparators
`timescale 1ns/1ns
`include "ass_defs.vh"
module ass_cap_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [2:0] softstart_cap_ctl_i,
  output wire logic       cap_at_1v3_o,
  output wire logic       cap_discharged_o
);
  // ----
  // Cap voltage in tenths of a volt
  // ----
  logic [5:0] level;
  // One step per cycle keeps runs short; residual charge at power-up
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      level <= 6'h05;
    end else begin
      case (softstart_cap_ctl_i)
        `ASS_CAP_DISCH:  level <= (level != 6'h00) ? level - 6'h01 : level;
        `ASS_CAP_HOLD0:  level <= 6'h00;
        `ASS_CAP_CHARGE: level <= (level < 6'h28) ? level + 6'h01 : level;
        `ASS_CAP_HOLD12: level <= 6'h0C;
        default:         level <= (level > 6'h14) ? level - 6'h01 : level;
      endcase
    end
  end
  // Comparator outputs
  assign cap_at_1v3_o     = level >= 6'h0D;
  assign cap_discharged_o = level == 6'h00;
endmodule

// File: tb/ass_seq_checker.sv
// Assertion checker on the sleep-state sequencer ports
`timescale 1ns/1ns
`include "ass_defs.vh"
module ass_seq_checker (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       uvlo_ok_i,
  input wire logic       startup_done_i,
  input wire logic       main5_good_i,
  input wire logic       main5_above_4v5_i,
  input wire logic       cap_at_1v3_i,
  input wire logic       cap_discharged_i,
  input wire logic       standby_request_n_i,
  input wire logic       soft_off_enable_n_i,
  input wire logic       memory_supply_en_o,
  input wire logic       termination_en_o,
  input wire logic       always_on_33_en_o,
  input wire logic       standby_status_out_n_o,
  input wire logic       standby_switch_gate_o,
  input wire logic [1:0] gate_drive_o,
  input wire logic       pass_fet_en_o,
  input wire logic [2:0] softstart_cap_ctl_o,
  input wire logic       memory_supply_good_o,
  input wire logic [4:0] state_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ----
  // State steps
  // ----
  sequence s3_entry; state_o == 5'h10 ##1 state_o == 5'h08; endsequence
  sequence s0_entry; state_o == 5'h08 ##1 state_o == 5'h10; endsequence
  sequence s5_exit; state_o == 5'h02 ##1 state_o == 5'h04; endsequence
  sequence start_exit; state_o == 5'h01 ##1 state_o != 5'h01; endsequence
  // Flags pass a two-flop sync, so causes are looked for 2 or 3 edges back
  s5_rails_a: assert property (state_o == 5'h02 |-> always_on_33_en_o && !memory_supply_en_o && !termination_en_o)
    else $error("S5 rail enables wrong");
  start_hold_a: assert property (start_exit |-> $past(startup_done_i, 2) || $past(startup_done_i, 3))
    else $error("Left start without startup done");
  mem_main_a: assert property (!main5_good_i [*4] |-> !memory_supply_en_o)
    else $error("Memory supply on without main good");
  s5_cap_a: assert property (state_o == 5'h02 |-> softstart_cap_ctl_o inside {`ASS_CAP_DISCH, `ASS_CAP_HOLD0})
    else $error("Cap not held low in S5");
  good_flag_a: assert property ($rose(memory_supply_good_o) |-> $past(cap_at_1v3_i, 2) || $past(cap_at_1v3_i, 3))
    else $error("Memory good without cap threshold");
  s3_enter_a: assert property (s3_entry |-> softstart_cap_ctl_o == `ASS_CAP_TO2V && !termination_en_o
    && !standby_switch_gate_o && !standby_status_out_n_o && always_on_33_en_o)
    else $error("S3 entry outputs wrong");
  s0_enter_a: assert property (s0_entry |-> ($past(main5_good_i, 2) || $past(main5_good_i, 3))
    && standby_status_out_n_o && standby_switch_gate_o && !always_on_33_en_o && termination_en_o)
    else $error("S0 entry outputs wrong");
  pass_fet_a: assert property (!main5_above_4v5_i [*4] |-> !pass_fet_en_o)
    else $error("Pass transistors on below 4.5V");
  gate_pull_a: assert property (s5_exit |-> !standby_switch_gate_o
    && gate_drive_o == (main5_good_i ? `ASS_GATE_STRONG : `ASS_GATE_WEAK))
    else $error("Gate pull strength wrong");
endmodule
bind ass_sequencer ass_seq_checker ass_seq_checker_inst (.*);

// File: tb/tb_top.sv
// Self-checking bench for the sleep-state sequencer
`timescale 1ns/1ns
`include "ass_defs.vh"
module tb_top;
  logic       clk_i, reset_i, uvlo_ok_i, startup_done_i, main5_good_i, main5_above_4v5_i;
  logic       standby_request_n_i, soft_off_enable_n_i;
  wire        at_1v3, disch, mem_en, term_en, alw_en, status_n, gate, pass_en, good;
  wire  [1:0] drive;
  wire  [2:0] cap_ctl;
  wire  [4:0] state;
  int         mismatches, n_compared;
  ass_sequencer ass_sequencer_inst (.clk_i(clk_i), .reset_i(reset_i), .uvlo_ok_i(uvlo_ok_i),
    .startup_done_i(startup_done_i), .main5_good_i(main5_good_i), .main5_above_4v5_i(main5_above_4v5_i),
    .cap_at_1v3_i(at_1v3), .cap_discharged_i(disch), .standby_request_n_i(standby_request_n_i),
    .soft_off_enable_n_i(soft_off_enable_n_i), .memory_supply_en_o(mem_en), .termination_en_o(term_en),
    .always_on_33_en_o(alw_en), .standby_status_out_n_o(status_n), .standby_switch_gate_o(gate),
    .gate_drive_o(drive), .pass_fet_en_o(pass_en), .softstart_cap_ctl_o(cap_ctl),
    .memory_supply_good_o(good), .state_o(state));
  ass_cap_model ass_cap_model_inst (.clk_i(clk_i), .reset_i(reset_i), .softstart_cap_ctl_i(cap_ctl),
    .cap_at_1v3_o(at_1v3), .cap_discharged_o(disch));
  // ----
  // Shared helpers
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait; a miss shows up in the compare that follows
  task automatic wait_st(input logic [4:0] s, input int lim, output int n);
    for (n = 0; n < lim && state !== s; n++) @(negedge clk_i);
  endtask
  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_startup;
    int n;
    repeat (20) @(negedge clk_i);
    chk({state, mem_en}, {5'h01, 1'b0});
    @(posedge clk_i) startup_done_i <= 1'b1;
    wait_st(5'h02, 10, n);
    chk({state, alw_en, mem_en, term_en}, {5'h02, 3'b100});
  endtask
  task automatic t_to_s3;
    int n;
    @(posedge clk_i) soft_off_enable_n_i <= 1'b1;
    wait_st(5'h04, 10, n);
    chk({state, gate, drive}, {5'h04, 1'b0, `ASS_GATE_STRONG});
    wait_st(5'h08, 6000, n);
    chk(n >= `ASS_SETTLE_CYC - 4 && n <= `ASS_SETTLE_CYC + 4, 1'b1);
    chk({mem_en, cap_ctl}, {1'b1, `ASS_CAP_CHARGE});
    for (n = 0; n < 50 && good !== 1'b1; n++) @(negedge clk_i);
    repeat (20) @(negedge clk_i);
    chk({good, state, cap_ctl}, {1'b1, 5'h08, `ASS_CAP_HOLD12});
  endtask
  task automatic t_to_s0;
    int n;
    @(posedge clk_i) main5_good_i <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk(mem_en, 1'b0);
    @(posedge clk_i) standby_request_n_i <= 1'b1;
    repeat (20) @(negedge clk_i);
    chk(state, 5'h08);
    @(posedge clk_i) begin
      main5_good_i <= 1'b1;
      main5_above_4v5_i <= 1'b1;
    end
    wait_st(5'h10, 10, n);
    chk({status_n, gate, alw_en, term_en, cap_ctl}, {4'b1101, `ASS_CAP_CHARGE});
    chk({state, mem_en, pass_en}, {5'h10, 2'b11});
  endtask
  task automatic t_back_s3;
    int n;
    @(posedge clk_i) standby_request_n_i <= 1'b0;
    wait_st(5'h08, 10, n);
    chk({status_n, gate, alw_en, term_en, cap_ctl}, {4'b0010, `ASS_CAP_TO2V});
    repeat (10) @(negedge clk_i);
    chk({state, cap_ctl}, {5'h08, `ASS_CAP_TO2V});
  endtask
  task automatic t_soft_off;
    int n;
    @(posedge clk_i) begin
      soft_off_enable_n_i <= 1'b0;
      main5_good_i <= 1'b0;
      main5_above_4v5_i <= 1'b0;
    end
    wait_st(5'h02, 10, n);
    chk({state, alw_en, mem_en, term_en}, {5'h02, 3'b100});
    @(posedge clk_i) soft_off_enable_n_i <= 1'b1;
    wait_st(5'h04, 10, n);
    chk({state, gate, drive, mem_en}, {5'h04, 1'b0, `ASS_GATE_WEAK, 1'b0});
    @(posedge clk_i) uvlo_ok_i <= 1'b0;
    wait_st(5'h01, 10, n);
    chk(state, 5'h01);
  endtask
  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Main sequence
  initial begin
    {uvlo_ok_i, startup_done_i, main5_good_i, main5_above_4v5_i} = 4'b1010;
    standby_request_n_i = 1'b0;
    soft_off_enable_n_i = 1'b0;
    mismatches = 0;
    n_compared = 0;
    reset_i = 1'b1;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    t_startup;
    t_to_s3;
    t_to_s0;
    t_back_s3;
    t_soft_off;
    give_verdict;
  end
  // Watchdog: the scenarios need about 5150 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    give_verdict;
  end
endmodule
